/* File: smrc_pkg.sv */
package smrc_pkg;
    localparam logic [2:0] STS_RESET = 3'h5;
    localparam logic [7:0] RCF_RESET = 8'h00;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
    localparam int CLK_HZ = 125000000;
    localparam int LS_DIV = 512;
    localparam int LS_PAUSE_PERIODS = 17;
    localparam int EXT_RESET_MIN_US = 10;
    localparam int EXT_RESET_MIN_CYC = (EXT_RESET_MIN_US * (CLK_HZ / 1000000));
    localparam int TIMER2_LS_DIV_EXP = 7;
    localparam logic [2:0] TH_SEL_11 = 3'h1;
    localparam logic [2:0] TH_SEL_13 = 3'h2;
    localparam logic [2:0] TH_SEL_14 = 3'h3;
    localparam logic [2:0] TH_SEL_15 = 3'h4;
    localparam logic [2:0] TH_SEL_16 = 3'h5;
    localparam int STAB_CNT_W = 17;
    localparam int RCF_WDT_BIT = 0;
    localparam int RCF_CLM_BIT = 1;
    localparam int RCF_LVD_BIT = 2;
    typedef enum logic [2:0]
    {
        SMRC_RUN = 3'b000,
        SMRC_STOP = 3'b001,
        SMRC_STAB = 3'b010,
        SMRC_RST = 3'b011,
        SMRC_PAUSE = 3'b100
    } smrc_state_t;
endpackage

/* File: smrc_stab_counter.sv */
`timescale 1ns/1ps
module smrc_stab_counter
    import smrc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic run,
    input wire logic [2:0] sel,
    input wire logic bypass,
    output logic [4:0] status,
    output logic done
);
    logic [STAB_CNT_W-1:0] cnt_q;
    logic [4:0] hit;
    // counter saturates at the selected threshold, so status shows only thresholds up to it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else if (clear)
            cnt_q <= '0;
        else if (run && !done)
            cnt_q <= cnt_q + 1'b1;
    end
    assign hit[4] = cnt_q >= STAB_CNT_W'(1 << 11);
    assign hit[3] = cnt_q >= STAB_CNT_W'(1 << 13);
    assign hit[2] = cnt_q >= STAB_CNT_W'(1 << 14);
    assign hit[1] = cnt_q >= STAB_CNT_W'(1 << 15);
    assign hit[0] = cnt_q >= STAB_CNT_W'(1 << 16);
    assign status = hit;
    always_comb
    begin
        unique case (sel)
            TH_SEL_11: done = hit[4] || bypass;
            TH_SEL_13: done = hit[3] || bypass;
            TH_SEL_14: done = hit[2] || bypass;
            TH_SEL_15: done = hit[1] || bypass;
            TH_SEL_16: done = hit[0] || bypass;
            default: done = hit[0] || bypass;
        endcase
    end
endmodule

/* File: smrc_ls_divider.sv */
`timescale 1ns/1ps
module smrc_ls_divider
    import smrc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    output logic tick
);
    logic [9:0] cnt_q;
    // low-speed oscillator period stands in as one enable pulse every LS_DIV cycles
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else if (!run)
            cnt_q <= '0;
        else if (cnt_q == 10'(LS_DIV - 1))
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end
    assign tick = run && (cnt_q == 10'(LS_DIV - 1));
endmodule

/* File: smrc_top.sv */
`timescale 1ns/1ps
module smrc_top
    import smrc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reset_pin_n,
    input wire logic wdt_overflow,
    input wire logic clk_mon_stop_det,
    input wire logic poc_low,
    input wire logic lvd_low,
    input wire logic stop_instr,
    input wire logic cpu_on_low_speed,
    input wire logic hs_src_no_wait,
    input wire logic interrupt_request_flag,
    input wire logic interrupt_mask_flag,
    input wire logic interrupt_priority_flag,
    input wire logic interrupt_accept_flag,
    input wire logic in_service_priority_flag,
    input wire logic timer2_on_ls_div,
    input wire logic csi_on_sync_serial_ext_clock,
    input wire logic sts_wr,
    input wire logic [2:0] sts_wdata,
    input wire logic rcf_rd,
    output logic [2:0] stab_time_select_reg,
    output logic [4:0] stab_time_status_reg,
    output logic [2:0] reset_cause_flags,
    output logic hs_osc_en,
    output logic ls_osc_en,
    output logic cpu_clk_en,
    output logic cpu_on_ls_start,
    output logic in_standby,
    output logic port_latch_hold,
    output logic pins_hiz,
    output logic reset_indicator_port_pin,
    output logic cpu_reset,
    output logic [15:0] pc_vector_addr,
    output logic wake_service,
    output logic wake_next_instr,
    output logic timer2_run,
    output logic clocked_serial_unit_run,
    output logic other_periph_run,
    output logic lvd_circuit_reset
);
    logic rst_s1_q, rst_n_q;
    logic pin_s1_q, pin_s2_q, wdt_s1_q, wdt_s2_q, clm_s1_q, clm_s2_q;
    logic poc_s1_q, poc_s2_q, lvd_s1_q, lvd_s2_q;
    logic irq_s1_q, irq_s2_q;
    logic any_rst, unmasked, want_service;
    logic wake_req_q, wake_svc_q;
    logic [4:0] pause_cnt_q;
    logic [4:0] stab_status;
    logic stab_done, ls_tick, stab_clear, stab_run;
    logic [2:0] sts_q;
    logic [2:0] rcf_q;
    smrc_state_t state_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // every pin-side input crosses into clk_sys through two flops
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            {pin_s1_q, pin_s2_q} <= 2'h3;
            {wdt_s1_q, wdt_s2_q} <= 2'h0;
            {clm_s1_q, clm_s2_q} <= 2'h0;
            {poc_s1_q, poc_s2_q} <= 2'h0;
            {lvd_s1_q, lvd_s2_q} <= 2'h0;
            {irq_s1_q, irq_s2_q} <= 2'h0;
        end
        else
        begin
            pin_s1_q <= reset_pin_n;
            pin_s2_q <= pin_s1_q;
            wdt_s1_q <= wdt_overflow;
            wdt_s2_q <= wdt_s1_q;
            clm_s1_q <= clk_mon_stop_det;
            clm_s2_q <= clm_s1_q;
            poc_s1_q <= poc_low;
            poc_s2_q <= poc_s1_q;
            lvd_s1_q <= lvd_low;
            lvd_s2_q <= lvd_s1_q;
            irq_s1_q <= interrupt_request_flag;
            irq_s2_q <= irq_s1_q;
        end
    end

    assign any_rst = !pin_s2_q || wdt_s2_q || clm_s2_q || poc_s2_q || lvd_s2_q;
    assign unmasked = irq_s2_q && !interrupt_mask_flag;
    always_comb
    begin
        if (!interrupt_priority_flag)
            want_service = interrupt_accept_flag;
        else
            want_service = interrupt_accept_flag && in_service_priority_flag;
    end

    // clear on standby entry, throughout standby or during a reset, so status bits stay set while running
    assign stab_clear = (state_q == SMRC_STOP) || any_rst || ((state_q == SMRC_RUN) && stop_instr);
    assign stab_run = (state_q == SMRC_STAB) || (state_q == SMRC_RST);

    smrc_stab_counter u_stab
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .clear(stab_clear),
        .run(stab_run),
        .sel(sts_q),
        .bypass(hs_src_no_wait),
        .status(stab_status),
        .done(stab_done)
    );

    smrc_ls_divider u_ls
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .run(state_q == SMRC_PAUSE),
        .tick(ls_tick)
    );

    // select register: reset loads 05h; writes outside the legal codes are ignored
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
            sts_q <= STS_RESET;
        else if (sts_wr && sts_wdata >= TH_SEL_11 && sts_wdata <= TH_SEL_16)
            sts_q <= sts_wdata;
    end

    // cause flags: hardware set wins over a read clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
            rcf_q <= RCF_RESET[2:0];
        else if (!pin_s2_q || poc_s2_q)
            rcf_q <= 3'h0;
        else
        begin
            rcf_q[RCF_WDT_BIT] <= wdt_s2_q || (rcf_q[RCF_WDT_BIT] && !rcf_rd);
            rcf_q[RCF_CLM_BIT] <= clm_s2_q || (rcf_q[RCF_CLM_BIT] && !rcf_rd);
            rcf_q[RCF_LVD_BIT] <= lvd_s2_q || (rcf_q[RCF_LVD_BIT] && !rcf_rd);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= SMRC_RST;
            pause_cnt_q <= '0;
            wake_req_q <= 1'b0;
            wake_svc_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                SMRC_RUN:
                begin
                    wake_req_q <= 1'b0;
                    if (any_rst)
                        state_q <= SMRC_RST;
                    else if (stop_instr && unmasked)
                    begin
                        state_q <= SMRC_STAB;
                        wake_svc_q <= want_service;
                    end
                    else if (stop_instr)
                        state_q <= SMRC_STOP;
                end
                SMRC_STOP:
                begin
                    if (any_rst)
                        state_q <= SMRC_RST;
                    else if (unmasked)
                    begin
                        state_q <= SMRC_STAB;
                        wake_svc_q <= want_service;
                    end
                end
                SMRC_STAB:
                begin
                    if (any_rst)
                        state_q <= SMRC_RST;
                    else if (stab_done || cpu_on_low_speed)
                    begin
                        state_q <= SMRC_RUN;
                        wake_req_q <= 1'b1;
                    end
                end
                SMRC_RST:
                begin
                    // reset sequence waits out stabilization before the low-speed pause
                    pause_cnt_q <= '0;
                    if (!any_rst && stab_done)
                        state_q <= SMRC_PAUSE;
                end
                SMRC_PAUSE:
                begin
                    if (any_rst)
                        state_q <= SMRC_RST;
                    else if (ls_tick)
                    begin
                        if (pause_cnt_q == 5'(LS_PAUSE_PERIODS - 1))
                            state_q <= SMRC_RUN;
                        else
                            pause_cnt_q <= pause_cnt_q + 1'b1;
                    end
                end
                default: state_q <= SMRC_RST;
            endcase
        end
    end

    // all outputs registered
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            hs_osc_en <= 1'b0;
            ls_osc_en <= 1'b0;
            cpu_clk_en <= 1'b0;
            cpu_on_ls_start <= 1'b0;
            in_standby <= 1'b0;
            port_latch_hold <= 1'b0;
            pins_hiz <= 1'b1;
            reset_indicator_port_pin <= 1'b0;
            cpu_reset <= 1'b1;
            pc_vector_addr <= RESET_VECTOR_ADDR;
            wake_service <= 1'b0;
            wake_next_instr <= 1'b0;
            timer2_run <= 1'b0;
            clocked_serial_unit_run <= 1'b0;
            other_periph_run <= 1'b0;
            lvd_circuit_reset <= 1'b0;
            stab_time_select_reg <= STS_RESET;
            stab_time_status_reg <= '0;
            reset_cause_flags <= '0;
        end
        else
        begin
            hs_osc_en <= (state_q != SMRC_STOP) && pin_s2_q;
            ls_osc_en <= pin_s2_q;
            cpu_clk_en <= state_q == SMRC_RUN;
            cpu_on_ls_start <= (state_q == SMRC_PAUSE) && ls_tick
                && (pause_cnt_q == 5'(LS_PAUSE_PERIODS - 1));
            in_standby <= state_q == SMRC_STOP;
            port_latch_hold <= state_q == SMRC_STOP || state_q == SMRC_STAB;
            pins_hiz <= state_q == SMRC_RST || state_q == SMRC_PAUSE;
            reset_indicator_port_pin <= !(state_q == SMRC_RST || state_q == SMRC_PAUSE);
            cpu_reset <= state_q == SMRC_RST || state_q == SMRC_PAUSE;
            pc_vector_addr <= RESET_VECTOR_ADDR;
            wake_service <= wake_req_q && wake_svc_q;
            wake_next_instr <= wake_req_q && !wake_svc_q;
            timer2_run <= (state_q != SMRC_STOP) || timer2_on_ls_div;
            clocked_serial_unit_run <= (state_q != SMRC_STOP) || csi_on_sync_serial_ext_clock;
            other_periph_run <= state_q == SMRC_RUN;
            lvd_circuit_reset <= (!pin_s2_q || poc_s2_q) && !lvd_s2_q;
            stab_time_select_reg <= sts_q;
            stab_time_status_reg <= stab_status;
            reset_cause_flags <= rcf_q;
        end
    end
endmodule

/* File: smrc_far_model.sv */
`timescale 1ns/1ps
module smrc_far_model
    import smrc_pkg::*;
(
    input wire logic clk_sys,
    output logic reset_pin_n,
    output logic wdt_overflow,
    output logic clk_mon_stop_det,
    output logic poc_low,
    output logic lvd_low,
    output logic irq,
    output logic [3:0] flags
);
    // source index: 0 pin, 1 watchdog, 2 clock monitor, 3 power-on, 4 low voltage
    logic [4:0] src = 5'h00;
    int held = 0;

    initial
    begin
        irq = 1'b0;
        flags = 4'h8;
    end

    assign reset_pin_n = ~src[0];
    assign {lvd_low, poc_low, clk_mon_stop_det, wdt_overflow} = src[4:1];

    always @(posedge clk_sys)
        held <= src[0] ? held + 1 : 0;

    // flags: mask, priority, accept, in-service
    task automatic set_irq(input logic r, input logic [3:0] f);
        irq <= r;
        flags <= f;
    endtask

    task automatic src_set(input int s, input logic v);
        // an early pin release is stretched, never shortened
        if (s == 0 && !v)
            while (held < EXT_RESET_MIN_CYC) @(posedge clk_sys);
        src[s] <= v;
    endtask
endmodule

/* File: smrc_assertions.sv */
`timescale 1ns/1ps
module smrc_checker
    import smrc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reset_pin_n,
    input wire logic lvd_low,
    input wire logic timer2_on_ls_div,
    input wire logic csi_on_sync_serial_ext_clock,
    input wire logic [2:0] stab_time_select_reg,
    input wire logic [4:0] stab_time_status_reg,
    input wire logic hs_osc_en,
    input wire logic ls_osc_en,
    input wire logic cpu_clk_en,
    input wire logic in_standby,
    input wire logic port_latch_hold,
    input wire logic pins_hiz,
    input wire logic reset_indicator_port_pin,
    input wire logic cpu_reset,
    input wire logic [15:0] pc_vector_addr,
    input wire logic wake_service,
    input wire logic wake_next_instr,
    input wire logic timer2_run,
    input wire logic clocked_serial_unit_run,
    input wire logic other_periph_run,
    input wire logic lvd_circuit_reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_standby_cpu_stop: assert property (in_standby |-> !cpu_clk_en)
        else $error("cpu clock runs in standby");
    a_standby_latch_hold: assert property (in_standby |-> port_latch_hold)
        else $error("port latches not held in standby");
    a_standby_periph_halt: assert property (in_standby |-> !other_periph_run)
        else $error("peripherals run in standby");
    a_timer2_gate: assert property (in_standby && $past(in_standby) && $stable(timer2_on_ls_div)
        |-> timer2_run == timer2_on_ls_div)
        else $error("second timer gating wrong in standby");
    a_serial_gate: assert property (in_standby && $past(in_standby) && $stable(csi_on_sync_serial_ext_clock)
        |-> clocked_serial_unit_run == csi_on_sync_serial_ext_clock)
        else $error("clocked serial gating wrong in standby");
    a_reset_pin_state: assert property (cpu_reset |-> pins_hiz && !reset_indicator_port_pin)
        else $error("pins not forced during reset");
    a_reset_vector_addr: assert property (cpu_reset |-> pc_vector_addr == 16'h0000)
        else $error("reset vector address wrong");
    a_wake_one_kind: assert property (wake_service |-> !wake_next_instr ##1 !wake_service)
        else $error("wake outcome not a single exclusive pulse");
    a_status_thermo: assert property (stab_time_status_reg inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f})
        else $error("status bits not set in order");
    a_select_legal: assert property (stab_time_select_reg inside {[3'h1:3'h5]})
        else $error("select holds a prohibited code");
    a_pin_osc_stop: assert property (!reset_pin_n [*4] |-> !hs_osc_en && !ls_osc_en)
        else $error("oscillator runs while reset pin low");
    a_lvd_keep_self: assert property (lvd_low |-> !lvd_circuit_reset)
        else $error("low-voltage reset resets its own detector");

    c_service: cover property (wake_service);
    c_next_instr: cover property (wake_next_instr);
    c_timer2_standby: cover property (in_standby && timer2_run);
    c_reset: cover property (cpu_reset);
endmodule

bind smrc_top smrc_checker u_chk (.clk_sys, .arst_n, .reset_pin_n, .lvd_low, .timer2_on_ls_div,
    .csi_on_sync_serial_ext_clock, .stab_time_select_reg, .stab_time_status_reg, .hs_osc_en, .ls_osc_en,
    .cpu_clk_en, .in_standby, .port_latch_hold, .pins_hiz, .reset_indicator_port_pin, .cpu_reset,
    .pc_vector_addr, .wake_service, .wake_next_instr, .timer2_run, .clocked_serial_unit_run,
    .other_periph_run, .lvd_circuit_reset);

/* File: stop_mode_and_reset_control_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
`define WAITN(c, lim) begin n = 0; while (!(c) && n < (lim)) begin @(negedge clk_sys); n++; end \
    if (!(c)) n_mismatch++; end
module stop_mode_and_reset_control_tb
    import smrc_pkg::*;
;
    logic clk_sys = 1'b0, arst_n = 1'b0, stop_instr = 1'b0, cpu_on_low_speed = 1'b0, hs_src_no_wait = 1'b1;
    logic timer2_on_ls_div = 1'b0, csi_on_sync_serial_ext_clock = 1'b0, sts_wr = 1'b0, rcf_rd = 1'b0;
    logic [2:0] sts_wdata = 3'h0;
    logic reset_pin_n, wdt_overflow, clk_mon_stop_det, poc_low, lvd_low, irq;
    logic [3:0] flg;
    logic [2:0] stab_time_select_reg, reset_cause_flags;
    logic [4:0] stab_time_status_reg;
    logic [15:0] pc_vector_addr;
    logic hs_osc_en, ls_osc_en, cpu_clk_en, cpu_on_ls_start, in_standby, port_latch_hold, pins_hiz;
    logic reset_indicator_port_pin, cpu_reset, wake_service, wake_next_instr, timer2_run;
    logic clocked_serial_unit_run, other_periph_run, lvd_circuit_reset;
    int comparisons = 0, n_mismatch = 0, cyc = 0;
    logic [6:0] tbl [9] = '{7'h02, 7'h13, 7'h2a, 7'h32, 7'h3b, 7'h22, 7'h11, 7'h0c, 7'h53};

    smrc_far_model u_far (.clk_sys, .reset_pin_n, .wdt_overflow, .clk_mon_stop_det, .poc_low, .lvd_low,
        .irq, .flags(flg));
    smrc_top u_dut (.clk_sys, .arst_n, .reset_pin_n, .wdt_overflow, .clk_mon_stop_det, .poc_low, .lvd_low,
        .stop_instr, .cpu_on_low_speed, .hs_src_no_wait, .interrupt_request_flag(irq),
        .interrupt_mask_flag(flg[3]), .interrupt_priority_flag(flg[2]), .interrupt_accept_flag(flg[1]),
        .in_service_priority_flag(flg[0]), .timer2_on_ls_div, .csi_on_sync_serial_ext_clock, .sts_wr,
        .sts_wdata, .rcf_rd, .stab_time_select_reg, .stab_time_status_reg, .reset_cause_flags, .hs_osc_en,
        .ls_osc_en, .cpu_clk_en, .cpu_on_ls_start, .in_standby, .port_latch_hold, .pins_hiz,
        .reset_indicator_port_pin, .cpu_reset, .pc_vector_addr, .wake_service, .wake_next_instr, .timer2_run,
        .clocked_serial_unit_run, .other_periph_run, .lvd_circuit_reset);

    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // a hang anywhere ends the run well inside the cycle budget
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic stop_pulse();
        @(posedge clk_sys);
        stop_instr <= 1'b1;
        @(posedge clk_sys);
        stop_instr <= 1'b0;
    endtask

    // e: pending, priority, accept, in-service, low-speed cpu, no wait, service expected
    task automatic stop_run(input logic [6:0] e);
        int n;
        @(posedge clk_sys);
        {hs_src_no_wait, cpu_on_low_speed, timer2_on_ls_div, csi_on_sync_serial_ext_clock} <= {e[1], e[2], e[3], e[4]};
        u_far.set_irq(e[6], {~e[6], e[5:3]});
        // let the request clear its synchroniser so it is pending when stop is taken
        @(posedge clk_sys);
        stop_pulse();
        if (!e[6])
        begin
            repeat (6) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK({in_standby, hs_osc_en, cpu_clk_en, port_latch_hold}, 4'h9)
            `CHK({other_periph_run, timer2_run, clocked_serial_unit_run}, {1'b0, e[3], e[4]})
            @(posedge clk_sys);
            u_far.set_irq(1'b1, {1'b1, e[5:3]});
            repeat (8) @(negedge clk_sys);
            `CHK(in_standby, 1'b1)
            @(posedge clk_sys);
            u_far.set_irq(1'b1, {1'b0, e[5:3]});
        end
        `WAITN(wake_service | wake_next_instr, 3000)
        `CHK({wake_service, wake_next_instr}, {e[0], ~e[0]})
        if (e[2:1] == 2'b00)
            `CHK({n >= 2048, n < 2100, stab_time_status_reg}, {2'b11, 5'h10})
        else
            `CHK(n < 100, 1'b1)
        @(posedge clk_sys);
        u_far.set_irq(1'b0, 4'h8);
    endtask

    task automatic rst_run(input int s, input logic st, input logic [2:0] exp);
        int n, h;
        h = (s == 0) ? EXT_RESET_MIN_CYC + 20 : 20;
        if (st)
            stop_pulse();
        @(posedge clk_sys);
        u_far.src_set(s, 1'b1);
        `WAITN(cpu_reset, 20)
        `CHK({pins_hiz, reset_indicator_port_pin, pc_vector_addr}, {2'b10, 16'h0000})
        `CHK(lvd_circuit_reset, s == 0 || s == 3)
        repeat (h) @(negedge clk_sys);
        if (s == 0) `CHK({hs_osc_en, ls_osc_en}, 2'b00)
        @(posedge clk_sys);
        u_far.src_set(s, 1'b0);
        `WAITN(cpu_on_ls_start, 20000)
        `CHK({n + h >= LS_PAUSE_PERIODS * LS_DIV, n < 9000}, 2'b11)
        @(negedge clk_sys);
        `CHK({cpu_clk_en, pins_hiz, in_standby, cpu_reset, reset_cause_flags}, {4'b1000, exp})
        $display("test reset source %0d done", s);
    endtask

    initial
    begin
        int n;
        logic [2:0] es;
        es = 3'h5;
        repeat (3) @(negedge clk_sys);
        `CHK({stab_time_select_reg, reset_cause_flags, pins_hiz, reset_indicator_port_pin}, 8'ha2)
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        `WAITN(cpu_on_ls_start, 20000)
        `CHK(n > 8000, 1'b1)
        $display("test power-up done");
        for (int v = 0; v < 8; v++)
        begin
            @(posedge clk_sys);
            {sts_wr, sts_wdata} <= {1'b1, v[2:0]};
            @(posedge clk_sys);
            sts_wr <= 1'b0;
            repeat (2) @(negedge clk_sys);
            if (v >= 1 && v <= 5)
                es = v[2:0];
            `CHK(stab_time_select_reg, es)
        end
        // short threshold so the waited wake stays cheap
        @(posedge clk_sys);
        {sts_wr, sts_wdata} <= {1'b1, 3'h1};
        @(posedge clk_sys);
        sts_wr <= 1'b0;
        $display("test select codes done");
        foreach (tbl[i])
            stop_run(tbl[i]);
        $display("test standby wake done");
        @(posedge clk_sys);
        hs_src_no_wait <= 1'b1;
        rst_run(1, 1'b1, 3'h1);
        rst_run(2, 1'b0, 3'h3);
        rst_run(4, 1'b0, 3'h7);
        @(posedge clk_sys);
        rcf_rd <= 1'b1;
        @(posedge clk_sys);
        rcf_rd <= 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK(reset_cause_flags, 3'h0)
        rst_run(1, 1'b0, 3'h1);
        rst_run(0, 1'b0, 3'h0);
        rst_run(2, 1'b0, 3'h2);
        rst_run(3, 1'b0, 3'h0);
        wrap_up();
    end
endmodule
